/* rtl/rx_dsp_adapt_defines.vh */
// register offsets, field positions and reset values of the receive dsp config bank
`ifndef RX_DSP_ADAPT_DEFINES_VH
`define RX_DSP_ADAPT_DEFINES_VH
// ==========================================================
// register indices (byte address is four times the index)
`define FFE_SEQUENCE_CTRL_IDX      12'h30f
`define EQUALIZER_MODE_CTRL_IDX    12'h311
`define EQUALIZER_FORCE_COEFFS_IDX 12'h313
`define TIMING_LOOP_GAIN_CTRL_IDX  12'h31c
`define LOW_POWER_FREEZE_MASKS_IDX 12'h31f
// ==========================================================
// reset values
`define FFE_SEQUENCE_CTRL_RST      16'h0464
`define EQUALIZER_MODE_CTRL_RST    16'h01fc
`define EQUALIZER_FORCE_COEFFS_RST 16'h06f8
`define TIMING_LOOP_GAIN_CTRL_RST  16'h1101
`define LOW_POWER_FREEZE_MASKS_RST 16'hfc36
// ==========================================================
// writable bit masks, reserved positions are zero
`define FFE_SEQUENCE_CTRL_MASK      16'h07ff
`define EQUALIZER_MODE_CTRL_MASK    16'he1fe
`define EQUALIZER_FORCE_COEFFS_MASK 16'hffff
`define TIMING_LOOP_GAIN_CTRL_MASK  16'hffff
`define LOW_POWER_FREEZE_MASKS_MASK 16'hfffe
// ==========================================================
// field positions
`define FIRST_TIMER_MSB   10
`define FIRST_TIMER_LSB   8
`define STATE_ONE_HOLD    7
`define STATE_TWO_HOLD    6
`define STATE_THREE_HOLD  5
`define CHECK_EN_MSB      4
`define CHECK_EN_LSB      2
`define FREQ_ACC_CLR      1
`define DFE_SWEEP_RESET   0
`define GAIN_MAP_MSB      15
`define GAIN_MAP_LSB      14
`define COEFF_SET_SEL     13
`define COEFF0_SHORT_MSB  8
`define COEFF0_SHORT_LSB  1
`define COEFF0_LONG_MSB   15
`define COEFF0_LONG_LSB   8
`define COEFF1_SHORT_MSB  7
`define COEFF1_SHORT_LSB  0
`define PROP_OVR_EN       15
`define INT_OVR_EN        14
`define PROP_VAL_MSB      13
`define PROP_VAL_LSB      11
`define INT_VAL_MSB       10
`define INT_VAL_LSB       7
`define PROP_HOLD_EN      6
`define PROP_HOLD_VAL     5
`define INT_HOLD_EN       4
`define INT_HOLD_VAL      3
`define DETECTOR_INVERT   2
`define ENERGY_IN_SEL     1
`define PRECURSOR_EN      0
`define IDLE_MASK_MSB     15
`define IDLE_MASK_LSB     11
`define WAKE_MASK_MSB     10
`define WAKE_MASK_LSB     6
`define FLUSH_MASK_MSB    5
`define FLUSH_MASK_LSB    1
`endif

/* rtl/rx_dsp_adapt_config_regs.v */
// wishbone register bank holding the 100 Mb/s receive dsp adaptation configuration
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`include "rx_dsp_adapt_defines.vh"
// Functional notes
// RQ1: first equalizer state timer, bits 10-8, reset 4
// RQ2: state one/two/three freeze bits, reset 0,1,1
// RQ3: sweep metric check enables, bits 4-2, reset 1
// RQ4: bit 1 reinitializes frequency accumulator per sweep
// RQ5: bit 0 resets feedback equalizer per sweep
// RQ6: gain mapping select, three valid values only
// RQ7: bit 13 picks equalizer coefficient set
// RQ8: coefficient zero under 75 m, reset fe
// RQ9: coefficient zero above 130 m, reset 06
// RQ10: coefficient one under 75 m, reset f8
// RQ11: bit 15 forces proportional gain value
// RQ12: bit 14 forces integral gain value
// RQ13: proportional arm hold enable and value
// RQ14: integral arm hold enable and value
// RQ15: energy input select, slicer or adc
// RQ16: pre-cursor metric enable, reset one
// RQ17: idle freeze group mask, reset 1f
// RQ18: wake and flush group masks
// RQ19: reserved bits read zero, ignore writes
module rx_dsp_adapt_config_regs (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [13:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        wb_err_o,
  input  wire [1:0]  seq_state,
  input  wire [2:0]  cable_class,
  output wire [2:0]  first_eq_state_timer,
  output wire        ffe_hold,
  output wire [2:0]  sweep_check_enable,
  output wire        sweep_freq_acc_clear,
  output wire        sweep_dfe_reset,
  output wire [1:0]  gain_mapping_select,
  output wire        ls_coeff_select,
  output wire [7:0]  eq_coeff0_force,
  output wire [7:0]  eq_coeff1_force,
  output wire        prop_gain_override_enable,
  output wire [2:0]  prop_gain_override_value,
  output wire        integral_gain_override_enable,
  output wire [3:0]  integral_gain_override_value,
  output wire        prop_arm_hold,
  output wire        prop_arm_hold_force,
  output wire        integral_arm_hold,
  output wire        integral_arm_hold_force,
  output wire        timing_detector_invert,
  output wire        energy_from_adc,
  output wire        precursor_metric_enable,
  output wire [4:0]  group_hold
);
  // ==========================================================
  // sequencer state codes
  localparam [1:0] ST_RUN   = 2'h0;
  localparam [1:0] ST_IDLE  = 2'h1;
  localparam [1:0] ST_WAKE  = 2'h2;
  localparam [1:0] ST_FLUSH = 2'h3;
  // cable length and equalizer state codes seen on cable_class when not adapting
  localparam [2:0] CAB_SHORT = 3'h0;
  localparam [2:0] CAB_LONG  = 3'h2;
  localparam [2:0] EQ_ONE    = 3'h4;
  localparam [2:0] EQ_TWO    = 3'h5;
  localparam [2:0] EQ_THREE  = 3'h6;

  // ==========================================================
  // registers
  reg  [15:0] ffe_sequence_ctrl_reg;
  reg  [15:0] equalizer_mode_ctrl_reg;
  reg  [15:0] equalizer_force_coeffs_reg;
  reg  [15:0] timing_loop_gain_ctrl_reg;
  reg  [15:0] low_power_freeze_masks_reg;
  reg  [15:0] wr_data;
  reg  [15:0] rd_data;
  reg         hit;
  wire [11:0] idx;
  wire        req;
  wire        wr_en;

  assign idx      = wb_adr_i[13:2];
  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_en    = req & wb_we_i;
  // unmapped word still gets ack with zero data, no bus error
  assign wb_err_o = 1'b0;

  // byte lanes 0 and 1 carry the 16-bit register
  always @* begin
    wr_data = wb_dat_i[15:0];
    hit     = 1'b1;
    rd_data = 16'h0000;
    case (idx)
      `FFE_SEQUENCE_CTRL_IDX:      rd_data = ffe_sequence_ctrl_reg;
      `EQUALIZER_MODE_CTRL_IDX:    rd_data = equalizer_mode_ctrl_reg;
      `EQUALIZER_FORCE_COEFFS_IDX: rd_data = equalizer_force_coeffs_reg;
      `TIMING_LOOP_GAIN_CTRL_IDX:  rd_data = timing_loop_gain_ctrl_reg;
      `LOW_POWER_FREEZE_MASKS_IDX: rd_data = low_power_freeze_masks_reg;
      default:                     hit     = 1'b0;
    endcase
  end

  function [15:0] merge;
    input [15:0] old;
    input [15:0] din;
    input [3:0]  sel;
    input [15:0] msk;
    reg   [15:0] lane;
    begin
      lane  = {{8{sel[1]}}, {8{sel[0]}}};
      merge = ((old & ~lane) | (din & lane)) & msk; // RQ19
    end
  endfunction

  // ==========================================================
  // bus slave, one registered ack per request, in the cycle after it
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= {16'h0000, hit ? rd_data : 16'h0000};
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      ffe_sequence_ctrl_reg      <= `FFE_SEQUENCE_CTRL_RST;      // RQ1
      equalizer_mode_ctrl_reg    <= `EQUALIZER_MODE_CTRL_RST;    // RQ8
      equalizer_force_coeffs_reg <= `EQUALIZER_FORCE_COEFFS_RST; // RQ9
      timing_loop_gain_ctrl_reg  <= `TIMING_LOOP_GAIN_CTRL_RST;  // RQ16
      low_power_freeze_masks_reg <= `LOW_POWER_FREEZE_MASKS_RST; // RQ17
    end else if (wr_en) begin
      case (idx)
        `FFE_SEQUENCE_CTRL_IDX: begin
          ffe_sequence_ctrl_reg <= merge(ffe_sequence_ctrl_reg, wr_data,
                                         wb_sel_i, `FFE_SEQUENCE_CTRL_MASK);
        end
        `EQUALIZER_MODE_CTRL_IDX: begin
          equalizer_mode_ctrl_reg <= merge(equalizer_mode_ctrl_reg, wr_data,
                                           wb_sel_i, `EQUALIZER_MODE_CTRL_MASK);
        end
        `EQUALIZER_FORCE_COEFFS_IDX: begin
          equalizer_force_coeffs_reg <= merge(equalizer_force_coeffs_reg, wr_data,
                                              wb_sel_i, `EQUALIZER_FORCE_COEFFS_MASK);
        end
        `TIMING_LOOP_GAIN_CTRL_IDX: begin
          timing_loop_gain_ctrl_reg <= merge(timing_loop_gain_ctrl_reg, wr_data,
                                             wb_sel_i, `TIMING_LOOP_GAIN_CTRL_MASK);
        end
        `LOW_POWER_FREEZE_MASKS_IDX: begin
          low_power_freeze_masks_reg <= merge(low_power_freeze_masks_reg, wr_data,
                                              wb_sel_i, `LOW_POWER_FREEZE_MASKS_MASK);
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // equalizer sequence controls
  reg ffe_hold_next;
  assign first_eq_state_timer =
    ffe_sequence_ctrl_reg[`FIRST_TIMER_MSB:`FIRST_TIMER_LSB]; // RQ1
  always @* begin
    case (cable_class)
      EQ_ONE:   ffe_hold_next = ffe_sequence_ctrl_reg[`STATE_ONE_HOLD];   // RQ2
      EQ_TWO:   ffe_hold_next = ffe_sequence_ctrl_reg[`STATE_TWO_HOLD];   // RQ2
      EQ_THREE: ffe_hold_next = ffe_sequence_ctrl_reg[`STATE_THREE_HOLD]; // RQ2
      default:  ffe_hold_next = 1'b0;
    endcase
  end
  assign ffe_hold             = ffe_hold_next;
  assign sweep_check_enable   =
    ffe_sequence_ctrl_reg[`CHECK_EN_MSB:`CHECK_EN_LSB];       // RQ3
  assign sweep_freq_acc_clear = ffe_sequence_ctrl_reg[`FREQ_ACC_CLR];    // RQ4
  assign sweep_dfe_reset      = ffe_sequence_ctrl_reg[`DFE_SWEEP_RESET]; // RQ5

  // ==========================================================
  // equalizer mode and forced coefficients
  wire [1:0] map_raw;
  assign map_raw             = equalizer_mode_ctrl_reg[`GAIN_MAP_MSB:`GAIN_MAP_LSB];
  // value 3 is not a defined mapping, fall back to the default
  assign gain_mapping_select = (map_raw == 2'h3) ? 2'h0 : map_raw; // RQ6
  assign ls_coeff_select     = equalizer_mode_ctrl_reg[`COEFF_SET_SEL]; // RQ7
  // middle cable lengths take the under 75 m coefficient zero value and no forced coefficient one value
  assign eq_coeff0_force = (cable_class == CAB_LONG) ?
    equalizer_force_coeffs_reg[`COEFF0_LONG_MSB:`COEFF0_LONG_LSB] :    // RQ9
    equalizer_mode_ctrl_reg[`COEFF0_SHORT_MSB:`COEFF0_SHORT_LSB];      // RQ8
  assign eq_coeff1_force = (cable_class == CAB_SHORT) ?
    equalizer_force_coeffs_reg[`COEFF1_SHORT_MSB:`COEFF1_SHORT_LSB] :  // RQ10
    8'h00;

  // ==========================================================
  // timing loop
  assign prop_gain_override_enable     = timing_loop_gain_ctrl_reg[`PROP_OVR_EN]; // RQ11
  assign prop_gain_override_value      =
    timing_loop_gain_ctrl_reg[`PROP_VAL_MSB:`PROP_VAL_LSB];                    // RQ11
  assign integral_gain_override_enable = timing_loop_gain_ctrl_reg[`INT_OVR_EN];  // RQ12
  assign integral_gain_override_value  =
    timing_loop_gain_ctrl_reg[`INT_VAL_MSB:`INT_VAL_LSB];                      // RQ12
  assign prop_arm_hold_force     = timing_loop_gain_ctrl_reg[`PROP_HOLD_EN];   // RQ13
  assign prop_arm_hold           = timing_loop_gain_ctrl_reg[`PROP_HOLD_EN] &
                                   timing_loop_gain_ctrl_reg[`PROP_HOLD_VAL];  // RQ13
  assign integral_arm_hold_force = timing_loop_gain_ctrl_reg[`INT_HOLD_EN];    // RQ14
  assign integral_arm_hold       = timing_loop_gain_ctrl_reg[`INT_HOLD_EN] &
                                   timing_loop_gain_ctrl_reg[`INT_HOLD_VAL];   // RQ14
  assign timing_detector_invert  = timing_loop_gain_ctrl_reg[`DETECTOR_INVERT];
  assign energy_from_adc         = timing_loop_gain_ctrl_reg[`ENERGY_IN_SEL]; // RQ15
  assign precursor_metric_enable = timing_loop_gain_ctrl_reg[`PRECURSOR_EN];  // RQ16

  // ==========================================================
  // low power idle group holds
  reg [4:0] group_hold_next;
  always @* begin
    case (seq_state)
      ST_IDLE:  group_hold_next =
        low_power_freeze_masks_reg[`IDLE_MASK_MSB:`IDLE_MASK_LSB];   // RQ17
      ST_WAKE:  group_hold_next =
        low_power_freeze_masks_reg[`WAKE_MASK_MSB:`WAKE_MASK_LSB];   // RQ18
      ST_FLUSH: group_hold_next =
        low_power_freeze_masks_reg[`FLUSH_MASK_MSB:`FLUSH_MASK_LSB]; // RQ18
      default:  group_hold_next = 5'h00;
    endcase
  end
  assign group_hold = group_hold_next;
endmodule // rx_dsp_adapt_config_regs

/* verif/rx_dsp_adapt_config_regs_props.sv */
// bus handshake and output relation checks for the receive dsp config bank
`timescale 1ns/100ps
module rx_dsp_adapt_config_regs_props (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [31:0] wb_dat_o,
  input wire [1:0]  seq_state,
  input wire [2:0]  cable_class,
  input wire        ffe_hold,
  input wire [7:0]  eq_coeff1_force,
  input wire [1:0]  gain_mapping_select,
  input wire        prop_arm_hold,
  input wire        prop_arm_hold_force,
  input wire        integral_arm_hold,
  input wire        integral_arm_hold_force,
  input wire [4:0]  group_hold,
  input wire [2:0]  first_eq_state_timer,
  input wire        precursor_metric_enable
);
  // ======================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  chk_gain_map_legal: assert property (gain_mapping_select != 2'h3)
    else $error("illegal gain mapping");
  chk_prop_hold_pair: assert property (prop_arm_hold |-> prop_arm_hold_force)
    else $error("prop hold without enable");
  chk_int_hold_pair: assert property (integral_arm_hold |-> integral_arm_hold_force)
    else $error("integral hold without enable");
  chk_run_no_hold: assert property (seq_state == 2'h0 |-> group_hold == 5'h00)
    else $error("group hold in run state");
  chk_coeff1_class: assert property (cable_class != 3'h0 |-> eq_coeff1_force == 8'h00)
    else $error("coeff one forced off short cable");
  chk_ffe_hold_off: assert property (cable_class < 3'h4 |-> !ffe_hold)
    else $error("ffe hold outside eq states");
  // reset itself is the antecedent, so the default disable is overridden
  chk_reset_fields: assert property (disable iff (1'b0) !rst_n |=>
    first_eq_state_timer == 3'h4 && precursor_metric_enable) else $error("bad reset fields");
endmodule // rx_dsp_adapt_config_regs_props
bind rx_dsp_adapt_config_regs rx_dsp_adapt_config_regs_props i_rx_dsp_adapt_config_regs_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .seq_state(seq_state), .cable_class(cable_class),
  .ffe_hold(ffe_hold), .eq_coeff1_force(eq_coeff1_force),
  .gain_mapping_select(gain_mapping_select), .prop_arm_hold(prop_arm_hold),
  .prop_arm_hold_force(prop_arm_hold_force), .integral_arm_hold(integral_arm_hold),
  .integral_arm_hold_force(integral_arm_hold_force), .group_hold(group_hold),
  .first_eq_state_timer(first_eq_state_timer), .precursor_metric_enable(precursor_metric_enable));

/* verif/rx_dsp_adapt_config_regs_tb.sv */
// self-checking bench for the receive dsp config register bank
`timescale 1ns/100ps
module rx_dsp_adapt_config_regs_tb;
  // ======================================================
  // signals and tables
  reg         ref_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
  reg  [13:0] wb_adr_i;
  reg  [3:0]  wb_sel_i;
  reg  [31:0] wb_dat_i, rd;
  reg  [1:0]  seq_state;
  reg  [2:0]  cable_class;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, ffe_hold, prop_arm_hold, integral_arm_hold, energy_from_adc, pre_en;
  wire [2:0]  first_eq_state_timer;
  wire [1:0]  gain_mapping_select;
  wire [7:0]  eq_coeff0_force, eq_coeff1_force;
  wire [4:0]  group_hold;
  wire [2:0]  sweep_check_enable, prop_gain_override_value;
  wire [3:0]  integral_gain_override_value;
  wire        sweep_freq_acc_clear, sweep_dfe_reset, ls_coeff_select, wb_err_o;
  wire        prop_gain_override_enable, integral_gain_override_enable;
  wire        prop_arm_hold_force, integral_arm_hold_force, timing_detector_invert;
  integer     error_cnt, compares, i;
  localparam [59:0] idx_tab = {12'h31f, 12'h31c, 12'h313, 12'h311, 12'h30f};
  localparam [79:0] rst_tab = {16'hfc36, 16'h1101, 16'h06f8, 16'h01fc, 16'h0464};
  localparam [79:0] msk_tab = {16'hfffe, 16'hffff, 16'hffff, 16'he1fe, 16'h07ff};
  rx_dsp_adapt_config_regs i_rx_dsp_adapt_config_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .seq_state(seq_state),
    .cable_class(cable_class), .first_eq_state_timer(first_eq_state_timer),
    .ffe_hold(ffe_hold), .sweep_check_enable(sweep_check_enable),
    .sweep_freq_acc_clear(sweep_freq_acc_clear), .sweep_dfe_reset(sweep_dfe_reset),
    .gain_mapping_select(gain_mapping_select), .ls_coeff_select(ls_coeff_select),
    .eq_coeff0_force(eq_coeff0_force), .eq_coeff1_force(eq_coeff1_force),
    .prop_gain_override_enable(prop_gain_override_enable),
    .prop_gain_override_value(prop_gain_override_value),
    .integral_gain_override_enable(integral_gain_override_enable),
    .integral_gain_override_value(integral_gain_override_value),
    .prop_arm_hold(prop_arm_hold), .prop_arm_hold_force(prop_arm_hold_force),
    .integral_arm_hold(integral_arm_hold), .integral_arm_hold_force(integral_arm_hold_force),
    .timing_detector_invert(timing_detector_invert), .energy_from_adc(energy_from_adc),
    .precursor_metric_enable(pre_en), .group_hold(group_hold));
  // ======================================================
  // helpers
  task automatic check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic final_report;
    begin
      if (error_cnt == 0 && compares > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  // outputs are read in the active region of the edge, before the design's updates land
  task automatic wb_cycle(input we, input [11:0] ix, input [3:0] sel, input [15:0] d);
    integer n;
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {ix, 2'b00};
      wb_sel_i <= sel;
      wb_dat_i <= {16'h0000, d};
      n = 0;
      do begin
        @(posedge ref_clk);
        n = n + 1;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
        error_cnt = error_cnt + 1;
        final_report;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task automatic wr(input [11:0] ix, input [15:0] d);
    wb_cycle(1'b1, ix, 4'h3, d);
  endtask
  task automatic rd_chk(input [11:0] ix, input [15:0] exp);
    begin
      wb_cycle(1'b0, ix, 4'h3, 16'h0000);
      check(rd, {16'h0000, exp});
    end
  endtask
  // ======================================================
  // scenarios
  task automatic t_reset;
    begin
      check(first_eq_state_timer, 3'h4);
      check(pre_en, 1'b1);
      check(energy_from_adc, 1'b0);
      for (i = 0; i < 5; i = i + 1)
        rd_chk(idx_tab[i*12+:12], rst_tab[i*16+:16]);
    end
  endtask
  task automatic t_reserved;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        wr(idx_tab[i*12+:12], 16'hffff);
        rd_chk(idx_tab[i*12+:12], msk_tab[i*16+:16]);
        wr(idx_tab[i*12+:12], 16'h0000);
        rd_chk(idx_tab[i*12+:12], 16'h0000);
      end
      for (i = 0; i < 4; i = i + 1) begin
        wr(12'h311, i << 14);
        check(gain_mapping_select, (i == 3) ? 0 : i);
      end
    end
  endtask
  task automatic t_lanes_unmapped;
    begin
      wb_cycle(1'b1, 12'h31c, 4'h1, 16'habcd);
      rd_chk(12'h31c, 16'h00cd);
      wb_cycle(1'b1, 12'h31c, 4'hc, 16'h1234);
      rd_chk(12'h31c, 16'h00cd);
      wb_cycle(1'b1, 12'h31c, 4'h2, 16'habcd);
      rd_chk(12'h31c, 16'habcd);
      wr(12'h310, 16'hffff);
      rd_chk(12'h310, 16'h0000);
      rd_chk(12'h30f, 16'h0000);
    end
  endtask
  task automatic t_outputs;
    begin
      wr(12'h30f, 16'h00a0);
      for (i = 0; i < 4; i = i + 1) begin
        cable_class <= (i == 0) ? 3'h0 : i + 3;
        @(posedge ref_clk);
        check(ffe_hold, i == 1 || i == 3);
      end
      wr(12'h311, 16'h20b4);
      wr(12'h313, 16'h3c81);
      cable_class <= 3'h0;
      @(posedge ref_clk);
      check({eq_coeff0_force, eq_coeff1_force}, 16'h5a81);
      cable_class <= 3'h2;
      @(posedge ref_clk);
      check({eq_coeff0_force, eq_coeff1_force}, 16'h3c00);
      wr(12'h31c, 16'h0068);
      check({prop_arm_hold, integral_arm_hold}, 2'b10);
      wr(12'h31c, 16'h0018);
      check({prop_arm_hold, integral_arm_hold}, 2'b01);
      wr(12'h31f, 16'haaa6);
      for (i = 0; i < 4; i = i + 1) begin
        seq_state <= i;
        @(posedge ref_clk);
        check(group_hold, {5'h13, 5'h0a, 5'h15, 5'h00} >> (i * 5) & 20'h1f);
      end
    end
  endtask
  task automatic t_fields;
    begin
      wr(12'h30f, 16'h001f);
      check({sweep_check_enable, sweep_freq_acc_clear, sweep_dfe_reset}, 5'h1f);
      wr(12'h30f, 16'h0008);
      check({sweep_check_enable, sweep_freq_acc_clear, sweep_dfe_reset}, 5'h08);
      wr(12'h311, 16'h2000);
      check(ls_coeff_select, 1'b1);
      wr(12'h31c, 16'hed46);
      check({prop_gain_override_enable, integral_gain_override_enable,
             prop_gain_override_value, integral_gain_override_value,
             prop_arm_hold_force, integral_arm_hold_force, timing_detector_invert,
             energy_from_adc, pre_en}, 14'h3b56);
      check(wb_err_o, 1'b0);
    end
  endtask
  // ======================================================
  // clock and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    error_cnt = 0;
    compares = 0;
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
    seq_state = 2'h0;
    cable_class = 3'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset;
    t_reserved;
    t_lanes_unmapped;
    t_outputs;
    t_fields;
    final_report;
  end
endmodule // rx_dsp_adapt_config_regs_tb
